// ### srl_axil.sv
// AXI4-Lite slave front end: one write and one read in flight
`timescale 1ns/1ps
module srl_axil
   import srl_pkg::*;
(
   input wire logic clk_sys_i, // System clock
   input wire logic rst_i, // Asynchronous reset, high
   input wire logic [31:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   output logic [31:0] wr_addr_o, // Held write address
   output logic [31:0] wr_data_o, // Held write data
   output logic [3:0] wr_strb_o, // Held write strobes
   output logic wr_en_o, // One-cycle register write
   input wire logic wr_hit_i, // Held write address is mapped
   input wire logic [31:0] rd_data_i, // Read value for s_axi_araddr
   input wire logic rd_hit_i // s_axi_araddr is mapped
);
   typedef struct packed {
      logic aw_have;
      logic w_have;
      logic [31:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
      logic wr_en;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } srl_axs_t;
   srl_axs_t s_reg;
   srl_axs_t s_next;

   // Address and data may arrive in either order; answer once both are held
   always_comb
   begin
      s_next = s_reg;
      s_next.wr_en = 1'b0;
      if (s_reg.bvalid && s_axi_bready)
         s_next.bvalid = 1'b0;
      if (!s_reg.aw_have && !s_reg.bvalid && s_axi_awvalid)
      begin
         s_next.aw_have = 1'b1;
         s_next.addr = s_axi_awaddr;
      end
      if (!s_reg.w_have && !s_reg.bvalid && s_axi_wvalid)
      begin
         s_next.w_have = 1'b1;
         s_next.data = s_axi_wdata;
         s_next.strb = s_axi_wstrb;
      end
      if (s_reg.aw_have && s_reg.w_have)
      begin
         s_next.aw_have = 1'b0;
         s_next.w_have = 1'b0;
         s_next.wr_en = wr_hit_i;
         s_next.bvalid = 1'b1;
         s_next.bresp = wr_hit_i ? RESP_OKAY : RESP_DECERR;
      end
      // Read data is captured at the address handshake
      if (s_reg.rvalid && s_axi_rready)
         s_next.rvalid = 1'b0;
      else if (!s_reg.rvalid && s_axi_arvalid)
      begin
         s_next.rvalid = 1'b1;
         s_next.rdata = rd_hit_i ? rd_data_i : 32'h0;
         s_next.rresp = rd_hit_i ? RESP_OKAY : RESP_DECERR;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign s_axi_awready = !s_reg.aw_have && !s_reg.bvalid;
   assign s_axi_wready = !s_reg.w_have && !s_reg.bvalid;
   assign s_axi_bvalid = s_reg.bvalid;
   assign s_axi_bresp = s_reg.bresp;
   assign s_axi_arready = !s_reg.rvalid;
   assign s_axi_rvalid = s_reg.rvalid;
   assign s_axi_rdata = s_reg.rdata;
   assign s_axi_rresp = s_reg.rresp;
   assign wr_addr_o = s_reg.addr;
   assign wr_data_o = s_reg.data;
   assign wr_strb_o = s_reg.strb;
   assign wr_en_o = s_reg.wr_en;
endmodule

// ### srl_far.sv
// Far-end model: an A-device that answers the VBUS pulse only
`timescale 1ns/1ps
module srl_far (
   input wire logic clk_sys_i, // Clock
   input wire logic pullup_i, // Near pull-up on
   input wire logic vbus_i, // Near VBUS drive on
   input wire logic answer_i, // Far end willing to power up
   input wire logic far_pu_i, // Far pull-up on
   output logic dp_o, // Positive line level
   output logic dm_o, // Negative line level
   output logic vld_o // VBUS above both valid levels
);
   logic seen_reg = 1'b0;
   // Lines are pulled down, so a released line reads low
   assign dp_o = pullup_i | far_pu_i;
   assign dm_o = 1'b0;
   // Line pulse ignored; power comes up once the VBUS pulse ends
   always @(posedge clk_sys_i)
   begin
      if (vbus_i)
         seen_reg <= answer_i;
      else if (!answer_i)
         seen_reg <= 1'b0;
   end
   assign vld_o = seen_reg & ~vbus_i;
endmodule

// ### srl_pkg.sv
// Shared constants for the session request and line termination block
package srl_pkg;
   // Clock and protocol times, each in its printed unit
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned SE0_WAIT_US = 2000;
   localparam int unsigned LINE_PULSE_MIN_US = 5000;
   localparam int unsigned LINE_PULSE_MAX_US = 10000;
   localparam int unsigned REQ_TOTAL_MS = 100;
   localparam int unsigned REQ_FAIL_S = 5;
   localparam int unsigned DISCHARGE_MAX_MS = 100;
   localparam int unsigned VBUS_DRIVE_US = 20000;
   // Derived cycle counts; the pulse sits midway between its limits
   localparam int unsigned SE0_WAIT_CYC = SE0_WAIT_US * CLK_MHZ;
   localparam int unsigned LINE_PULSE_CYC = (LINE_PULSE_MIN_US + LINE_PULSE_MAX_US) / 2 * CLK_MHZ;
   localparam int unsigned REQ_TOTAL_CYC = REQ_TOTAL_MS * 1000 * CLK_MHZ;
   localparam int unsigned REQ_FAIL_CYC = REQ_FAIL_S * 1000000 * CLK_MHZ;
   localparam int unsigned DISCHARGE_MAX_CYC = DISCHARGE_MAX_MS * 1000 * CLK_MHZ;
   localparam int unsigned VBUS_DRIVE_CYC = VBUS_DRIVE_US * CLK_MHZ;
   // Register byte offsets
   localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
   localparam logic [31:0] OFS_STATUS = 32'h0000_0004;
   localparam logic [31:0] OFS_VBUS_TIME = 32'h0000_0008;
   // Control fields
   localparam int CTRL_START = 0;
   localparam int CTRL_ROLE_SWAP = 1;
   localparam int CTRL_DISCH_EN = 2;
   localparam int CTRL_RESP_DIS = 3;
   localparam int CTRL_TX_RELEASE = 4;
   // Status fields
   localparam int STAT_BUSY = 0;
   localparam int STAT_FAIL = 1;
   localparam int STAT_OK = 2;
   localparam int STAT_DETECT = 3;
   localparam int STAT_SESSION = 4;
   localparam int STAT_HOST = 5;
   localparam int STAT_STATE_LO = 8;
   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   // Request sequencer states
   typedef enum logic [2:0] {ST_IDLE, ST_PREP, ST_LINE, ST_VBUS, ST_WAIT} srl_state_t;
endpackage

// ### srl_timer.sv
// Saturating interval counter, cleared on demand
`timescale 1ns/1ps
module srl_timer
   import srl_pkg::*;
(
   input wire logic clk_sys_i, // System clock
   input wire logic rst_i, // Asynchronous reset, high
   input wire logic clear_i, // Restart from zero
   output logic [31:0] count_o // Cycles since last clear
);
   typedef struct packed {
      logic [31:0] cnt;
   } srl_tmr_t;
   srl_tmr_t s_reg;
   srl_tmr_t s_next;

   // Saturate so a very long wait never wraps to a short one
   always_comb
   begin
      s_next = s_reg;
      if (clear_i)
         s_next.cnt = 32'h0;
      else if (s_reg.cnt != 32'hffff_ffff)
         s_next.cnt = s_reg.cnt + 32'h1;
   end

   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign count_o = s_reg.cnt;
endmodule

// ### srl_top.sv
// Session request sequencer, request detector and data-line terminations
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module srl_top
   import srl_pkg::*;
#(
   parameter logic [31:0] SE0_CYC = SE0_WAIT_CYC,
   parameter logic [31:0] LINE_CYC = LINE_PULSE_CYC,
   parameter logic [31:0] TOTAL_CYC = REQ_TOTAL_CYC,
   parameter logic [31:0] FAIL_CYC = REQ_FAIL_CYC,
   parameter logic [31:0] DISCH_CYC = DISCHARGE_MAX_CYC,
   parameter logic [31:0] VBUS_CYC = VBUS_DRIVE_CYC
)
(
   input wire logic clk_sys_i, // System clock, 200 MHz
   input wire logic rst_i, // Asynchronous reset, high
   input wire logic [31:0] s_axi_awaddr, // AXI write address
   input wire logic s_axi_awvalid, // AXI write address valid
   output logic s_axi_awready, // AXI write address ready
   input wire logic [31:0] s_axi_wdata, // AXI write data
   input wire logic [3:0] s_axi_wstrb, // AXI write strobes
   input wire logic s_axi_wvalid, // AXI write data valid
   output logic s_axi_wready, // AXI write data ready
   output logic [1:0] s_axi_bresp, // AXI write response
   output logic s_axi_bvalid, // AXI write response valid
   input wire logic s_axi_bready, // AXI write response ready
   input wire logic [31:0] s_axi_araddr, // AXI read address
   input wire logic s_axi_arvalid, // AXI read address valid
   output logic s_axi_arready, // AXI read address ready
   output logic [31:0] s_axi_rdata, // AXI read data
   output logic [1:0] s_axi_rresp, // AXI read response
   output logic s_axi_rvalid, // AXI read data valid
   input wire logic s_axi_rready, // AXI read data ready
   input wire logic a_device_i, // Plug makes this end the A-device
   input wire logic dp_high_i, // Positive data line reads high
   input wire logic dm_high_i, // Negative data line reads high
   input wire logic tx_active_i, // Packet transmission under way
   input wire logic a_side_session_valid_level_i, // VBUS above A-side valid level
   input wire logic b_side_session_valid_level_i, // VBUS above B-side valid level
   input wire logic b_side_session_end_level_i, // VBUS below B-side end level
   output logic dp_pulldown_en_o, // Positive-line pull-down switched on
   output logic dm_pulldown_en_o, // Negative-line pull-down switched on
   output logic dp_pullup_en_o, // Positive-line pull-up switched on
   output logic vbus_drive_en_o, // Drive VBUS for the request pulse
   output logic vbus_discharge_path_o, // Switch in VBUS discharge path
   output logic session_o, // Session in progress
   output logic host_role_o, // This end currently acts as host
   output logic req_detected_o, // Sticky: far end requested a session
   output logic req_failed_o // Sticky: own request got no answer
);
   typedef struct packed {
      srl_state_t state;
      logic session;
      logic role_swap;
      logic disch_en;
      logic resp_dis;
      logic tx_release;
      logic [31:0] vbus_len;
      logic a_vld_d;
      logic req_ok;
      logic req_fail;
      logic req_det;
      logic dp_pd;
      logic dm_pd;
      logic dp_pu;
      logic vbus_drv;
      logic vbus_dis;
      logic host;
   } srl_core_t;
   srl_core_t s_reg;
   srl_core_t s_next;

   logic [31:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_en;
   logic wr_hit;
   logic rd_hit;
   logic [31:0] rd_data;
   logic [31:0] se0_cnt;
   logic [31:0] st_cnt;
   logic st_clr;
   logic se0_now;
   logic host_now;
   logic periph_now;
   logic [31:0] vbus_lim;

   srl_axil u_axil (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_addr_o(wr_addr),
      .wr_data_o(wr_data),
      .wr_strb_o(wr_strb),
      .wr_en_o(wr_en),
      .wr_hit_i(wr_hit),
      .rd_data_i(rd_data),
      .rd_hit_i(rd_hit)
   );

   // Idle interval on the lines: restarts whenever either line leaves SE0
   srl_timer u_se0_tmr (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .clear_i(!se0_now),
      .count_o(se0_cnt)
   );

   // Time spent in the current sequencer state
   srl_timer u_st_tmr (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .clear_i(st_clr),
      .count_o(st_cnt)
   );

   // Address decode; only whole-word aligned offsets are mapped
   assign wr_hit = (wr_addr == OFS_CTRL) || (wr_addr == OFS_STATUS) ||
      (wr_addr == OFS_VBUS_TIME);
   assign rd_hit = (s_axi_araddr == OFS_CTRL) || (s_axi_araddr == OFS_STATUS) ||
      (s_axi_araddr == OFS_VBUS_TIME);

   // Read mux; the start bit is a strobe and always reads zero
   always_comb
   begin
      rd_data = 32'h0;
      if (s_axi_araddr == OFS_CTRL)
      begin
         rd_data[CTRL_ROLE_SWAP] = s_reg.role_swap;
         rd_data[CTRL_DISCH_EN] = s_reg.disch_en;
         rd_data[CTRL_RESP_DIS] = s_reg.resp_dis;
         rd_data[CTRL_TX_RELEASE] = s_reg.tx_release;
      end
      else if (s_axi_araddr == OFS_STATUS)
      begin
         rd_data[STAT_BUSY] = (s_reg.state != ST_IDLE);
         rd_data[STAT_FAIL] = s_reg.req_fail;
         rd_data[STAT_OK] = s_reg.req_ok;
         rd_data[STAT_DETECT] = s_reg.req_det;
         rd_data[STAT_SESSION] = s_reg.session;
         rd_data[STAT_HOST] = host_now;
         rd_data[STAT_STATE_LO +: 3] = s_reg.state;
      end
      else if (s_axi_araddr == OFS_VBUS_TIME)
         rd_data = s_reg.vbus_len;
   end

   // Role view: A-device starts as host, a swap hands the role over
   assign se0_now = !dp_high_i && !dm_high_i;
   assign host_now = s_reg.session && (a_device_i ^ s_reg.role_swap);
   assign periph_now = s_reg.session && !host_now;
   // Keep the VBUS pulse inside the total request budget
   assign vbus_lim = (s_reg.vbus_len > TOTAL_CYC - LINE_CYC) ?
      TOTAL_CYC - LINE_CYC : s_reg.vbus_len;
   assign st_clr = (s_next.state != s_reg.state);

   // Next state of the whole block
   always_comb
   begin
      s_next = s_reg;
      s_next.a_vld_d = a_side_session_valid_level_i;
      // Session: opened at own valid level, closed below the A-side level
      if (!a_side_session_valid_level_i)
         s_next.session = 1'b0;
      else if (a_device_i ? a_side_session_valid_level_i : b_side_session_valid_level_i)
         s_next.session = 1'b1;
      if (!s_next.session)
         s_next.role_swap = 1'b0;
      // Hardware re-enables line detection when the lines go back to SE0
      if (se0_now)
         s_next.resp_dis = 1'b0;
      // Software writes; a resp_dis set from software wins over the SE0 clear above
      if (wr_en && wr_addr == OFS_CTRL && wr_strb[0])
      begin
         s_next.role_swap = wr_data[CTRL_ROLE_SWAP] && s_next.session;
         s_next.disch_en = wr_data[CTRL_DISCH_EN];
         s_next.resp_dis = wr_data[CTRL_RESP_DIS];
         s_next.tx_release = wr_data[CTRL_TX_RELEASE];
      end
      if (wr_en && wr_addr == OFS_STATUS && wr_strb[0])
      begin
         if (wr_data[STAT_FAIL])
            s_next.req_fail = 1'b0;
         if (wr_data[STAT_OK])
            s_next.req_ok = 1'b0;
         if (wr_data[STAT_DETECT])
            s_next.req_det = 1'b0;
      end
      if (wr_en && wr_addr == OFS_VBUS_TIME && wr_strb == 4'hf)
         s_next.vbus_len = wr_data;
      // Far-end request detection, line or VBUS method, set wins over clear
      if (a_device_i && !s_reg.session && !s_reg.resp_dis && (dp_high_i || dm_high_i))
         s_next.req_det = 1'b1;
      if (a_device_i && !s_reg.a_vld_d && a_side_session_valid_level_i && !s_reg.session)
         s_next.req_det = 1'b1;
      // Own request sequencer, B-device only
      case (s_reg.state)
         ST_IDLE:
         begin
            if (wr_en && wr_addr == OFS_CTRL && wr_strb[0] && wr_data[CTRL_START] &&
               !a_device_i && !s_reg.session)
               s_next.state = ST_PREP;
         end
         ST_PREP:
         begin
            if (a_device_i || s_reg.session)
               s_next.state = ST_IDLE;
            else if (b_side_session_end_level_i && se0_cnt >= SE0_CYC)
               s_next.state = ST_LINE;
         end
         ST_LINE:
         begin
            if (st_cnt >= LINE_CYC - 32'h1)
               s_next.state = ST_VBUS;
         end
         ST_VBUS:
         begin
            if (st_cnt >= vbus_lim - 32'h1)
               s_next.state = ST_WAIT;
         end
         ST_WAIT:
         begin
            if (b_side_session_valid_level_i)
            begin
               s_next.state = ST_IDLE;
               s_next.req_ok = 1'b1;
            end
            else if (st_cnt >= FAIL_CYC - 32'h1)
            begin
               s_next.state = ST_IDLE;
               s_next.req_fail = 1'b1;
            end
         end
         default:
            s_next.state = ST_IDLE;
      endcase
      // Role flag registered so the role output comes straight from a flop
      s_next.host = s_next.session && (a_device_i ^ s_next.role_swap);
      // Terminations follow role; transmit may release them when allowed
      s_next.dp_pd = !periph_now;
      s_next.dm_pd = 1'b1;
      s_next.dp_pu = periph_now || (s_next.state == ST_LINE);
      if (s_next.state == ST_LINE)
         s_next.dp_pd = 1'b0;
      if (tx_active_i && s_reg.tx_release && s_reg.session)
      begin
         s_next.dp_pd = 1'b0;
         s_next.dm_pd = 1'b0;
         s_next.dp_pu = 1'b0;
      end
      s_next.vbus_drv = (s_next.state == ST_VBUS);
      // Discharge only while waiting for session end, and never for long
      s_next.vbus_dis = (s_next.state == ST_PREP) && s_reg.disch_en &&
         !b_side_session_end_level_i && (st_cnt < DISCH_CYC);
   end

   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s_reg <= '0;
         s_reg.state <= ST_IDLE;
         s_reg.vbus_len <= VBUS_CYC;
         s_reg.dp_pd <= 1'b1;
         s_reg.dm_pd <= 1'b1;
      end
      else
         s_reg <= s_next;
   end

   assign dp_pulldown_en_o = s_reg.dp_pd;
   assign dm_pulldown_en_o = s_reg.dm_pd;
   assign dp_pullup_en_o = s_reg.dp_pu;
   assign vbus_drive_en_o = s_reg.vbus_drv;
   assign vbus_discharge_path_o = s_reg.vbus_dis;
   assign session_o = s_reg.session;
   assign host_role_o = s_reg.host;
   assign req_detected_o = s_reg.req_det;
   assign req_failed_o = s_reg.req_fail;

   // Cycles spent pulsing in the current request, for the budget check
   logic [31:0] act_cnt;
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
         act_cnt <= 32'h0;
      else if (s_reg.state == ST_LINE || s_reg.state == ST_VBUS)
         act_cnt <= act_cnt + 32'h1;
      else
         act_cnt <= 32'h0;
   end

   sequence s_line_done;
      s_reg.state == ST_LINE ##1 s_reg.state == ST_VBUS;
   endsequence

   sequence s_vbus_start;
      !vbus_drive_en_o ##1 vbus_drive_en_o;
   endsequence

   a_idle_pulldowns: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (!s_reg.session && s_reg.state == ST_IDLE) |=>
      (dp_pulldown_en_o && dm_pulldown_en_o))
      else $error("pull-downs not both on while idle");

   a_periph_terms: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (periph_now && !tx_active_i && a_side_session_valid_level_i) |=>
      (!dp_pulldown_en_o && dm_pulldown_en_o && dp_pullup_en_o))
      else $error("peripheral terminations wrong");

   a_tx_release: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (tx_active_i && s_reg.tx_release && s_reg.session) |=>
      (!dp_pulldown_en_o && !dm_pulldown_en_o && !dp_pullup_en_o))
      else $error("terminations not released during transmit");

   a_pulse_dp_only: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (s_reg.state == ST_LINE) |-> (dp_pullup_en_o && !vbus_drive_en_o))
      else $error("line pulse not on positive pull-up alone");

   a_line_first: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      s_vbus_start |-> $past(s_reg.state, 2) == ST_LINE)
      else $error("VBUS pulse not preceded by line pulse");

   a_line_width: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      s_line_done |-> $past(st_cnt, 1) == LINE_CYC - 32'h1)
      else $error("line pulse width wrong");

   a_start_conds: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (s_reg.state == ST_PREP && s_next.state == ST_LINE) |->
      (b_side_session_end_level_i && se0_cnt >= SE0_CYC))
      else $error("request began without SE0 and session end");

   a_total_bound: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      act_cnt <= TOTAL_CYC)
      else $error("request activity exceeded total time");

   a_fail_wait: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $rose(req_failed_o) |-> $past(st_cnt, 1) >= FAIL_CYC - 32'h1)
      else $error("failure reported too early");

   a_line_detect: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (a_device_i && !s_reg.session && !s_reg.resp_dis && dp_high_i) |=>
      req_detected_o)
      else $error("line request not detected");
endmodule

// ### srl_top_bench.sv
// Bench for the session request block, driven over AXI4-Lite
`timescale 1ns/1ps
module srl_top_bench
   import srl_pkg::*;
;
   localparam logic [31:0] LINE_C = 32'h1e;
   localparam logic [31:0] VB_C = 32'h14;
   localparam logic [31:0] FAIL_C = 32'hc8;
   logic clk_sys_i = 1'b0, rst_i = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, a_dev = 1'b0, tx = 1'b0, answer = 1'b0, far_pu = 1'b0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rdv;
   logic [1:0] bresp, rresp, rr;
   logic awready, wready, bvalid, arready, rvalid, dp, dm, vld;
   logic pd_p, pd_m, pu, vb, dis, ses, host, det, fail;
   logic hi_v = 1'b0;
   int fails = 0, checked = 0, pu_n = 0, vb_n = 0, pu_w = 0, n;
   srl_top #(.SE0_CYC(32'h14), .LINE_CYC(LINE_C), .TOTAL_CYC(32'h64), .FAIL_CYC(FAIL_C),
      .DISCH_CYC(32'h32), .VBUS_CYC(VB_C)) dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .a_device_i(a_dev),
      .dp_high_i(dp), .dm_high_i(dm), .tx_active_i(tx), .a_side_session_valid_level_i(vld),
      .b_side_session_valid_level_i(vld), .b_side_session_end_level_i(!vld && !hi_v),
      .dp_pulldown_en_o(pd_p), .dm_pulldown_en_o(pd_m), .dp_pullup_en_o(pu),
      .vbus_drive_en_o(vb), .vbus_discharge_path_o(dis), .session_o(ses),
      .host_role_o(host), .req_detected_o(det), .req_failed_o(fail));
   srl_far far_u (.clk_sys_i(clk_sys_i), .pullup_i(pu), .vbus_i(vb), .answer_i(answer),
      .far_pu_i(far_pu), .dp_o(dp), .dm_o(dm), .vld_o(vld));
   initial forever #2.5 clk_sys_i = ~clk_sys_i;
   // Pull-up cycles seen before the first VBUS drive, and VBUS drive cycles
   always @(posedge clk_sys_i)
   begin
      pu_n <= pu_n + int'(pu);
      vb_n <= vb_n + int'(vb);
      if (vb && vb_n == 0)
         pu_w <= pu_n;
   end
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) $display("[FAIL] %s exp %h got %h", nm, e, s);
      if (s !== e) fails++;
   endtask
   // Handshakes are taken at the rising edge; bready and rready stay high once raised,
   // so back-to-back calls never toggle them twice in one step
   task wr(input logic [31:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clk_sys_i);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end
      while (!bvalid);
   endtask
   task rd(input logic [31:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clk_sys_i);
         if (arready)
            arvalid <= 1'b0;
         rdv = rdata;
         rr = rresp;
      end
      while (!rvalid);
   endtask
   task test_done();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Watchdog: all tests need well under this span
   initial
   begin
      #50us;
      fails++;
      test_done();
   end
   initial
   begin
      repeat (16) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      chk("idle pulldowns", {pd_p, pd_m, pu}, 3'h6);
      rd(32'h40);
      chk("unmapped", rr, RESP_DECERR);
      $display("test reset done");
      answer <= 1'b1;
      wr(OFS_CTRL, 32'h1);
      for (n = 0; n < 999 && !ses; n++) @(posedge clk_sys_i);
      repeat (3) @(posedge clk_sys_i);
      chk("line pulse", pu_w, LINE_C);
      chk("vbus pulse", vb_n, VB_C);
      chk("periph terms", {pd_p, pd_m, pu, host}, 4'h6);
      rd(OFS_STATUS);
      chk("status", rdv, (32'h1 << STAT_OK) | (32'h1 << STAT_SESSION));
      wr(OFS_CTRL, 32'h2);
      repeat (2) @(posedge clk_sys_i);
      chk("host terms", {pd_p, pd_m, pu, host}, 4'hd);
      wr(OFS_CTRL, 32'h10);
      tx <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      chk("tx release", {pd_p, pd_m, pu}, 3'h0);
      tx <= 1'b0;
      answer <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      chk("session end", {pd_p, pd_m, ses}, 3'h6);
      $display("test request done");
      wr(OFS_VBUS_TIME, 32'h50);
      hi_v <= 1'b1;
      wr(OFS_CTRL, 32'h5);
      repeat (3) @(posedge clk_sys_i);
      chk("discharge on", dis, 1'b1);
      repeat (50) @(posedge clk_sys_i);
      chk("discharge limit", dis, 1'b0);
      chk("held for end level", pu, 1'b0);
      hi_v <= 1'b0;
      for (n = 0; n < 999 && !fail; n++) @(posedge clk_sys_i);
      chk("fail wait", {fail, n >= FAIL_C}, 2'h3);
      chk("vbus clamp", vb_n, VB_C + 32'h64 - LINE_C);
      $display("test fail done");
      a_dev <= 1'b1;
      far_pu <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      chk("detect", det, 1'b1);
      wr(OFS_CTRL, 32'h8);
      wr(OFS_STATUS, 32'h8);
      rd(OFS_STATUS);
      chk("detect off", rdv[STAT_DETECT], 1'b0);
      far_pu <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      rd(OFS_CTRL);
      chk("detect rearm", rdv[CTRL_RESP_DIS], 1'b0);
      $display("test detect done");
      test_done();
   end
endmodule
